// >>> common/wdt_pkg.sv
// Types shared by the watchdog and reset-cause block
package wdt_pkg;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_IRQ = 2'b01,
    MODE_RESET = 2'b10,
    MODE_BOTH = 2'b11
  } dog_mode_t;

endpackage

// >>> common/wdt_regs.svh
// Register map, field positions, reset values and timing counts of the watchdog and reset-cause block
// Notes on behaviour
// - Counter advances on ticks of 128 kHz oscillator
// - Restart clears counter before time-out fires
// - Interrupt mode: expiry raises interrupt, no reset
// - Reset mode: expiry causes system reset
// - Combined mode: interrupt first, then reset
// - Always-on fuse forces reset mode, enables fixed
// - New prescaler and reset-enable clear accepted only within four cycles
// - Time-outs span 16 ms to 8 s
// - Watchdog reset pulse one cycle, delay follows
// - Watchdog flag bit 3, cleared by zero/power-on
// - Brown-out flag bit 2, cleared by zero/power-on
// - Pin reset flag bit 1, cleared by zero/power-on
// - Power-on flag bit 0, cleared only by zero
// - Enabled brown-out asserts after filter, core release delayed
// - Low supply counts only beyond 2 us
// - Interrupt flag bit 7, cleared by vector/one
// - Watchdog flag forces reset enable to one
// - Prescaler codes 0..9 give 2048..1048576 ticks
// - Combined mode vector clears enable and flag
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Word indices on the bus, byte address is four times these
`define WDT_ADR_CAUSE 6'h00
`define WDT_ADR_CTRL 6'h01

`define WDT_CAUSE_POR 0
`define WDT_CAUSE_EXT 1
`define WDT_CAUSE_BOD 2
`define WDT_CAUSE_DOG 3

`define WDT_CTRL_IRQF 7
`define WDT_CTRL_IRQE 6
`define WDT_CTRL_PS3 5
`define WDT_CTRL_CHG 4
`define WDT_CTRL_RSTE 3

`define WDT_CAUSE_RESET 4'h1
`define WDT_PS_RESET 4'h0
`define WDT_SYNC_INIT 7'h17

`define WDT_OSC_KHZ 128
`define WDT_MIN_TIMEOUT_MS 16
`define WDT_MAX_TIMEOUT_MS 8000
`define WDT_BASE_TICKS 2048
`define WDT_PS_MAX 4'h9
`define WDT_BOD_OFF 3'h7
`define WDT_CHG_WINDOW 3'h4

`define WDT_CLK_NS 25
`define WDT_BOD_MIN_NS 2000
`define WDT_BOD_CYCLES ((`WDT_BOD_MIN_NS + `WDT_CLK_NS - 1) / `WDT_CLK_NS)

`endif

// >>> verification/core_model.sv
// Processor core stand-in: timed restarts and watchdog vector entry
`timescale 1ns/100ps
module core_model (
  input wire logic i_clock, // System clock
  input wire logic i_kick, // Keep restarting
  input wire logic [15:0] i_gap, // Restart spacing
  input wire logic i_serve, // Take the vector
  input wire logic i_irq, // Watchdog interrupt
  output logic o_restart = 1'b0, // Restart pulse
  output logic o_vector_ack = 1'b0 // Vector entry
);
  logic [15:0] gap_q = 16'h0000;
  always @(posedge i_clock) begin
    gap_q <= (i_kick && gap_q < i_gap) ? gap_q + 16'h0001 : 16'h0000;
    o_restart <= i_kick && gap_q == i_gap;
    // Irq drops after entry, so one pulse each
    o_vector_ack <= i_serve && i_irq && !o_vector_ack;
  end
endmodule

// >>> verification/watchdog_reset_source_tb_top.sv
// Self-checking bench for the watchdog and reset-cause block
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module watchdog_reset_source_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic osc = 1'b0;
  logic low = 1'b0;
  logic pin_n = 1'b1;
  logic fuse_on = 1'b0;
  logic [2:0] lvl = 3'h7;
  logic kick = 1'b0;
  logic serve = 1'b0;
  logic [15:0] gap = 16'h0FA0;
  logic restart, vec, ack, irq, pulse, brown, core;
  logic [31:0] rdat;
  logic [31:0] rnd = 32'hA0F4C701;
  logic [7:0] exp_c;
  int fail_count = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  // Free-running, phase unrelated to clk
  always #51 osc = ~osc;
  watchdog_reset_source #(.STARTUP_CYCLES(8)) i_dut (.I_CLOCK(clk), .I_RESET(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_RESTART(restart),
    .I_VECTOR_ACK(vec), .I_OSC_128K(osc), .I_SUPPLY_LOW(low), .I_PIN_RESET_N(pin_n),
    .I_ALWAYS_ON_FUSE(fuse_on), .I_DROP_LEVEL_FUSE(lvl), .O_WB_ACK(ack), .O_WB_DAT(rdat),
    .O_DOG_IRQ(irq), .O_DOG_RESET_PULSE(pulse), .O_BROWNOUT_RESET(brown), .O_CORE_RESET(core));
  core_model i_core (.i_clock(clk), .i_kick(kick), .i_gap(gap), .i_serve(serve), .i_irq(irq),
    .o_restart(restart), .o_vector_ack(vec));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Cause flags after a software write: zeros clear, ones keep, upper bits read 0
  function automatic logic [7:0] cause_after(input logic [7:0] c, input logic [7:0] w);
    return c & w & 8'h0F;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk);
    // Only the watchdog process ends a wait that never answers
    while (ack !== 1'b1) @(posedge clk);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(n, e, q)
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    tick(90000);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(2);
    rc("cause", 8'h00, 8'h01);
    rc("ctrl", 8'h04, 8'h00);
    rc("unmapped", 8'h08, 8'h00);
    pin_n <= 1'b0;
    tick(10);
    pin_n <= 1'b1;
    tick(8);
    exp_c = 8'h03;
    rc("cause", 8'h00, exp_c);
    repeat (3) begin
      rnd = nxt(rnd);
      wr(8'h00, rnd[7:0]);
      exp_c = cause_after(exp_c, rnd[7:0]);
      rc("cause", 8'h00, exp_c);
    end
    sel <= 4'hE;
    wr(8'h00, 8'h00);
    sel <= 4'hF;
    rc("no sel", 8'h00, exp_c);
    wr(8'h00, 8'h00);
    low <= 1'b1;
    tick(150);
    `CHK("bod off", 1'b0, brown)
    low <= 1'b0;
    lvl <= 3'h0;
    tick(10);
    low <= 1'b1;
    tick(40);
    low <= 1'b0;
    tick(5);
    `CHK("short dip", 1'b0, brown)
    low <= 1'b1;
    tick(150);
    `CHK("bod", 1'b1, brown)
    `CHK("core bod", 1'b1, core)
    low <= 1'b0;
    tick(100);
    `CHK("core free", 1'b0, core)
    rc("cause", 8'h00, 8'h04);
    wr(8'h00, 8'h00);
    rnd = nxt(rnd);
    gap <= {4'h0, rnd[11:0]} + 16'h03E8;
    kick <= 1'b1;
    wr(8'h04, 8'h40);
    tick(12000);
    `CHK("kept alive", 1'b0, irq)
    kick <= 1'b0;
    repeat (9000) if (irq !== 1'b1) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    rc("ctrl", 8'h04, 8'hC0);
    rc("no reset", 8'h00, 8'h00);
    wr(8'h04, 8'h80);
    `CHK("irq clear", 1'b0, irq)
    serve <= 1'b1;
    wr(8'h04, 8'h48);
    repeat (9000) if (irq !== 1'b1) @(posedge clk);
    `CHK("irq first", 1'b1, irq)
    tick(4);
    rc("ctrl", 8'h04, 8'h08);
    repeat (9000) if (pulse !== 1'b1) @(posedge clk);
    `CHK("dog reset", 1'b1, pulse)
    tick(30);
    rc("cause", 8'h00, 8'h08);
    wr(8'h04, 8'h18);
    wr(8'h04, 8'h00);
    rc("forced", 8'h04, 8'h08);
    wr(8'h00, 8'h07);
    rc("cleared", 8'h00, 8'h00);
    wr(8'h04, 8'h18);
    tick(2);
    wr(8'h04, 8'h01);
    rc("late", 8'h04, 8'h08);
    wr(8'h04, 8'h18);
    wr(8'h04, 8'h21);
    rc("commit", 8'h04, 8'h21);
    fuse_on <= 1'b1;
    wr(8'h04, 8'h40);
    tick(5);
    rc("fuse", 8'h04, 8'h29);
    // Pin flag set, then a second power-on clears it
    pin_n <= 1'b0;
    tick(5);
    pin_n <= 1'b1;
    tick(5);
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(2);
    rc("por", 8'h00, 8'h01);
    wr(8'h00, 8'h00);
    rc("read clear", 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule

// >>> verification/wdt_checker.sv
// Port assertions of the watchdog and reset-cause block
`timescale 1ns/100ps
module wdt_checker (
  input wire logic I_CLOCK, // Clock
  input wire logic I_RESET, // Reset
  input wire logic I_WB_CYC, // Cycle
  input wire logic I_WB_STB, // Strobe
  input wire logic I_VECTOR_ACK, // Vector entry
  input wire logic I_SUPPLY_LOW, // Low supply
  input wire logic [2:0] I_DROP_LEVEL_FUSE, // Level fuse
  input wire logic O_WB_ACK, // Ack
  input wire logic [31:0] O_WB_DAT, // Read data
  input wire logic O_DOG_IRQ, // Interrupt
  input wire logic O_DOG_RESET_PULSE, // Dog reset
  input wire logic O_BROWNOUT_RESET, // Brown-out
  input wire logic O_CORE_RESET // Core reset
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  // Raw low-supply run length, saturating
  logic [7:0] low_q;
  logic [7:0] low_d;
  assign low_d = !I_SUPPLY_LOW ? 8'h00 : low_q + {7'h0, low_q != 8'hFF};
  always_ff @(posedge I_CLOCK) begin
    low_q <= low_d;
  end
  a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
  a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("no ack");
  a_dat_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("data outside ack");
  a_dat_upper: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0) else $error("upper bits set");
  a_pulse_single: assert property (O_DOG_RESET_PULSE |=> !O_DOG_RESET_PULSE) else $error("long pulse");
  a_pulse_stretch: assert property ($fell(O_DOG_RESET_PULSE) |-> ##1 O_CORE_RESET [*4]) else $error("no delay");
  a_vector_clear: assert property (I_VECTOR_ACK |=> !O_DOG_IRQ) else $error("irq after vector");
  a_bod_filter: assert property ($rose(O_BROWNOUT_RESET) |-> low_q >= 8'h50) else $error("short dip taken");
  a_bod_prompt: assert property (low_q == 8'h64 && I_DROP_LEVEL_FUSE != 3'h7 |-> O_BROWNOUT_RESET)
    else $error("brown-out late");
  a_bod_off: assert property (low_q == 8'h64 && I_DROP_LEVEL_FUSE == 3'h7 |-> !O_BROWNOUT_RESET)
    else $error("disabled brown-out fired");
  a_bod_core: assert property (O_BROWNOUT_RESET |=> O_CORE_RESET) else $error("core not held");
  c_irq: cover property (O_DOG_IRQ);
  c_pulse: cover property (O_DOG_RESET_PULSE);
  c_bod: cover property (O_BROWNOUT_RESET);
endmodule
bind watchdog_reset_source wdt_checker i_chk (.I_CLOCK, .I_RESET, .I_WB_CYC, .I_WB_STB, .I_VECTOR_ACK,
  .I_SUPPLY_LOW, .I_DROP_LEVEL_FUSE, .O_WB_ACK, .O_WB_DAT, .O_DOG_IRQ, .O_DOG_RESET_PULSE,
  .O_BROWNOUT_RESET, .O_CORE_RESET);

// >>> verilog/sync_edge.sv
// Two-flop synchroniser per bit with a rising-edge pulse behind it
`timescale 1ns/100ps
module sync_edge #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic i_clock,               // System clock
  input wire logic i_reset,               // Synchronous reset, active high
  input wire logic [WIDTH-1:0] i_async,   // Inputs from outside the clock domain
  output logic [WIDTH-1:0] o_sync,        // Synchronised level
  output logic [WIDTH-1:0] o_rise         // One-cycle pulse on a rising level
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      logic prev_q;
      // First flop feeds only the second
      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          meta_q <= INIT[g];
          sync_q <= INIT[g];
          prev_q <= INIT[g];
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign o_sync[g] = sync_q;
      assign o_rise[g] = sync_q & ~prev_q;
    end
  endgenerate

endmodule

// >>> verilog/watchdog_reset_source.sv
// Watchdog timer with timed configuration changes, brown-out filter and reset-cause flags
`timescale 1ns/100ps
`include "wdt_regs.svh"
module watchdog_reset_source #(
  parameter int STARTUP_CYCLES = 64,
  parameter int CNT_W = 21
) (
  input wire logic I_CLOCK,                  // System clock, 40 MHz
  input wire logic I_RESET,                  // Power-on reset, synchronous, active high
  input wire logic I_WB_CYC,                 // Wishbone cycle
  input wire logic I_WB_STB,                 // Wishbone strobe
  input wire logic I_WB_WE,                  // Wishbone write enable
  input wire logic [7:0] I_WB_ADR,           // Wishbone byte address
  input wire logic [3:0] I_WB_SEL,           // Wishbone byte selects
  input wire logic [31:0] I_WB_DAT,          // Wishbone write data
  input wire logic I_RESTART,                // Watchdog restart from the core, one cycle
  input wire logic I_VECTOR_ACK,             // Core enters the watchdog vector, one cycle
  input wire logic I_OSC_128K,               // Watchdog oscillator, asynchronous
  input wire logic I_SUPPLY_LOW,             // Supply below trigger, asynchronous
  input wire logic I_PIN_RESET_N,            // Reset pin, active low, asynchronous
  input wire logic I_ALWAYS_ON_FUSE,         // Always-on fuse programmed
  input wire logic [2:0] I_DROP_LEVEL_FUSE,  // Brown-out level fuse, 111 disables
  output logic O_WB_ACK,                     // Wishbone acknowledge
  output logic [31:0] O_WB_DAT,              // Wishbone read data
  output logic O_DOG_IRQ,                    // Watchdog interrupt, level
  output logic O_DOG_RESET_PULSE,            // Watchdog reset, one cycle
  output logic O_BROWNOUT_RESET,             // Brown-out reset, level
  output logic O_CORE_RESET                  // Stretched reset to the core
);

  generate
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_bad_startup
      $error("STARTUP_CYCLES must lie in 1..65535");
    end
    if (CNT_W < 21) begin : g_bad_width
      $error("CNT_W must be at least 21");
    end
    // Filter count register is seven bits wide
    if (`WDT_BOD_CYCLES > 127) begin : g_bad_filter
      $error("Brown-out filter count must fit in 7 bits");
    end
  endgenerate

  localparam logic [15:0] STARTUP_LOAD = 16'(STARTUP_CYCLES);
  localparam logic [6:0] BOD_CYC = 7'(`WDT_BOD_CYCLES);

  // Time-out in oscillator ticks; reserved codes behave as the longest
  function automatic logic [CNT_W-1:0] timeout_ticks(input logic [3:0] code);
    logic [3:0] sel;
    sel = (code > `WDT_PS_MAX) ? `WDT_PS_MAX : code;
    timeout_ticks = CNT_W'(`WDT_BASE_TICKS) << sel;
  endfunction

  // Word decode; the two low address bits are ignored
  function automatic logic word_hit(input logic [7:0] adr, input logic [5:0] idx);
    word_hit = adr[7:2] == idx;
  endfunction

  // Input synchronisation
  logic [6:0] pins_raw;
  logic [6:0] pins_sync;
  logic [6:0] pins_rise;
  logic osc_tick;
  logic supply_low;
  logic pin_reset;
  logic fuse_on;
  logic bod_on;

  // Fuses are synchronised too, as they may settle after power-up
  assign pins_raw = {I_OSC_128K, I_SUPPLY_LOW, I_PIN_RESET_N, I_ALWAYS_ON_FUSE, I_DROP_LEVEL_FUSE};

  sync_edge #(
    .WIDTH(7),
    .INIT(`WDT_SYNC_INIT)
  ) u_sync (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET),
    .i_async(pins_raw),
    .o_sync(pins_sync),
    .o_rise(pins_rise)
  );

  assign osc_tick = pins_rise[6];
  assign supply_low = pins_sync[5];
  assign pin_reset = ~pins_sync[4];
  assign fuse_on = pins_sync[3];
  assign bod_on = pins_sync[2:0] != `WDT_BOD_OFF;

  // Registers
  logic ack_q;
  logic [31:0] dat_q;
  logic irq_flag_q;
  logic irq_en_q;
  logic rst_en_q;
  logic [3:0] ps_q;
  logic [2:0] win_q;
  logic [CNT_W-1:0] count_q;
  logic dog_pulse_q;
  logic [3:0] cause_q;
  logic [6:0] low_cnt_q;
  logic bod_q;
  logic [15:0] start_q;
  logic core_q;
  logic irq_q;

  // Bus decode
  logic bus_req;
  logic bus_end;
  logic hit_cause;
  logic hit_ctrl;
  logic wr_cause;
  logic wr_ctrl;
  logic [7:0] wd;
  logic [31:0] rd_data;

  assign bus_req = I_WB_CYC & I_WB_STB & ~ack_q;
  // Writes land on the ack edge, where the master sees the answer
  assign bus_end = I_WB_CYC & I_WB_STB & ack_q;
  assign hit_cause = word_hit(I_WB_ADR, `WDT_ADR_CAUSE);
  assign hit_ctrl = word_hit(I_WB_ADR, `WDT_ADR_CTRL);
  assign wr_cause = bus_end & I_WB_WE & I_WB_SEL[0] & hit_cause;
  assign wr_ctrl = bus_end & I_WB_WE & I_WB_SEL[0] & hit_ctrl;
  assign wd = I_WB_DAT[7:0];

  // Effective enables
  logic rst_en_eff;
  logic irq_en_eff;
  wdt_pkg::dog_mode_t mode;

  assign rst_en_eff = rst_en_q | fuse_on | cause_q[`WDT_CAUSE_DOG];
  assign irq_en_eff = irq_en_q & ~fuse_on;
  assign mode = wdt_pkg::dog_mode_t'({rst_en_eff, irq_en_eff});

  // Timed change sequence
  logic open_seq;
  logic in_window;
  logic commit;
  logic [2:0] win_d;

  assign open_seq = wr_ctrl & wd[`WDT_CTRL_CHG] & wd[`WDT_CTRL_RSTE];
  assign in_window = win_q != 3'h0;
  assign commit = wr_ctrl & in_window & ~wd[`WDT_CTRL_CHG];
  assign win_d = open_seq ? `WDT_CHG_WINDOW : commit ? 3'h0 : in_window ? win_q - 3'h1 : 3'h0;

  // Counter and expiry
  logic running;
  logic tick;
  logic expire;
  logic irq_set;
  logic dog_fire;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] count_d;

  assign running = mode != wdt_pkg::MODE_STOP;
  assign limit = timeout_ticks(ps_q);
  assign tick = osc_tick & running & ~I_RESTART;
  // Compare with >= so a switch to a shorter time-out still expires at once
  assign expire = tick & (count_q >= limit - CNT_W'(1));
  assign count_d = (I_RESTART | ~running | expire) ? '0 : tick ? count_q + CNT_W'(1) : count_q;

  always_comb begin
    irq_set = 1'b0;
    dog_fire = 1'b0;
    case (mode)
      wdt_pkg::MODE_IRQ: begin
        irq_set = expire;
      end
      wdt_pkg::MODE_RESET: begin
        dog_fire = expire;
      end
      wdt_pkg::MODE_BOTH: begin
        // Unserviced interrupt means the next expiry resets
        irq_set = expire & ~irq_flag_q;
        dog_fire = expire & irq_flag_q;
      end
      default: begin
        irq_set = 1'b0;
        dog_fire = 1'b0;
      end
    endcase
  end

  // Control next values
  logic vec_both;
  logic irq_flag_d;
  logic irq_en_d;
  logic rst_en_d;
  logic [3:0] ps_d;

  assign vec_both = I_VECTOR_ACK & (mode == wdt_pkg::MODE_BOTH);
  // Set wins over a clear in the same cycle
  assign irq_flag_d = irq_set | (irq_flag_q & ~I_VECTOR_ACK & ~(wr_ctrl & wd[`WDT_CTRL_IRQF]));
  assign irq_en_d = vec_both ? 1'b0 : wr_ctrl ? wd[`WDT_CTRL_IRQE] : irq_en_q;
  assign rst_en_d = (commit ? wd[`WDT_CTRL_RSTE] : (rst_en_q | (wr_ctrl & wd[`WDT_CTRL_RSTE])))
                    | cause_q[`WDT_CAUSE_DOG];
  assign ps_d = commit ? {wd[`WDT_CTRL_PS3], wd[2:0]} : ps_q;

  // Brown-out filter
  logic low_seen;
  logic bod_d;
  logic [6:0] low_cnt_d;

  assign low_seen = supply_low & bod_on;
  assign low_cnt_d = ~low_seen ? 7'h00 : (low_cnt_q == BOD_CYC) ? low_cnt_q : low_cnt_q + 7'h01;
  // Short dips never reach the count; once asserted, held while low
  assign bod_d = low_seen & (bod_q | (low_cnt_q == BOD_CYC));

  // Reset-cause flags, set wins over a software clear
  logic [3:0] cause_set;
  logic [3:0] cause_keep;
  logic [3:0] cause_d;

  assign cause_set = {dog_fire, bod_d & ~bod_q, pin_reset, 1'b0};
  assign cause_keep = wr_cause ? wd[3:0] : 4'hF;
  assign cause_d = cause_set | (cause_q & cause_keep);

  // Start-up delay, counting from the end of the last active source
  logic any_src;
  logic [15:0] start_d;

  assign any_src = bod_q | pin_reset | dog_pulse_q;
  assign start_d = any_src ? STARTUP_LOAD : (start_q != 16'h0000) ? start_q - 16'h0001 : 16'h0000;

  // Read mux; the control word shows the forced enables, not the stored ones
  logic [7:0] ctrl_view;

  assign ctrl_view = {irq_flag_q, irq_en_eff, ps_q[3], in_window, rst_en_eff, ps_q[2:0]};

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_cause) begin
      rd_data = {28'h000_0000, cause_q};
    end else if (hit_ctrl) begin
      rd_data = {24'h00_0000, ctrl_view};
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

  // Bus slave
  // Read data is latched at the request edge and stands with ack
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      dat_q <= (bus_req & ~I_WB_WE) ? rd_data : 32'h0000_0000;
    end
  end

  // Watchdog control
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      irq_flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      rst_en_q <= 1'b0;
      ps_q <= `WDT_PS_RESET;
      win_q <= 3'h0;
    end else begin
      irq_flag_q <= irq_flag_d;
      irq_en_q <= irq_en_d;
      rst_en_q <= rst_en_d;
      ps_q <= ps_d;
      win_q <= win_d;
    end
  end

  // Counter, reset pulse and interrupt output
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      count_q <= '0;
      dog_pulse_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      count_q <= count_d;
      dog_pulse_q <= dog_fire;
      irq_q <= irq_flag_d & irq_en_d & ~fuse_on;
    end
  end

  // Reset sources and stretching
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      cause_q <= `WDT_CAUSE_RESET;
      low_cnt_q <= 7'h00;
      bod_q <= 1'b0;
      start_q <= STARTUP_LOAD;
      core_q <= 1'b1;
    end else begin
      cause_q <= cause_d;
      low_cnt_q <= low_cnt_d;
      bod_q <= bod_d;
      start_q <= start_d;
      core_q <= start_d != 16'h0000;
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = dat_q;
  assign O_DOG_IRQ = irq_q;
  assign O_DOG_RESET_PULSE = dog_pulse_q;
  assign O_BROWNOUT_RESET = bod_q;
  assign O_CORE_RESET = core_q;

endmodule
